// [common/pms_consts.vh]
// constants for the pwm module-stop control block
// Notes on behaviour
// - bit 3 of the high stop register stops both pwm channels together
// - each channel runs or stops from shared bit and own bit together
// - channel 1 runs when shared bit and bit 2 are both zero
// - channel 1 stops when shared bit is zero and bit 2 is one
// - channel 0 runs when shared bit and bit 1 are both zero
// - channel 0 stops when shared bit is zero and bit 1 is one
// - pwm registers clear on resets, module stop, standby; kept otherwise
// - converter registers clear on resets, module stop, standby; kept otherwise
`ifndef PMS_CONSTS_VH
`define PMS_CONSTS_VH

`define PMS_OFS_STOP_A 8'h00
`define PMS_OFS_STOP_H 8'h04
`define PMS_OFS_STATUS 8'h08
`define PMS_OFS_CH0 8'h10
`define PMS_OFS_CH1 8'h20
`define PMS_OFS_ADC 8'h30

`define PMS_STOP_A_RST 8'h00
`define PMS_STOP_H_RST 8'h00
`define PMS_BIT_CH1_STOP 2
`define PMS_BIT_CH0_STOP 1
`define PMS_BIT_SHARED 3

`define PMS_SEL_DUTY_A 2'd0
`define PMS_SEL_DUTY_B 2'd1
`define PMS_SEL_CTRL 2'd2
`define PMS_SEL_CNT 2'd3
`define PMS_CTRL_EN_BIT 0
`define PMS_CNT_MAX 14'h3fff

`define PMS_ADC_SEL_DATA 2'd0
`define PMS_ADC_SEL_CSR 2'd1
`define PMS_ADC_SEL_CR 2'd2

`endif

// [rtl/pms_pwm_chan.v]
// one 14-bit pwm channel with its register bank
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.vh"
module pms_pwm_chan (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire run, // channel may run
  input wire init, // synchronous clear of all registers
  input wire wr_en, // register write strobe
  input wire [1:0] wr_sel, // register select
  input wire [15:0] wdata, // write data
  output reg [15:0] duty_a_r, // duty register a
  output reg [15:0] duty_b_r, // duty register b
  output reg [7:0] ctrl_r, // control register
  output reg [13:0] cnt_r, // free counter
  output reg pwm_a_r, // pwm output a
  output reg pwm_b_r // pwm output b
);
  wire wr_ok;
  wire cnt_on;
  assign wr_ok = wr_en & run;
  assign cnt_on = run & ctrl_r[`PMS_CTRL_EN_BIT];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_a_r <= 16'h0000;
      duty_b_r <= 16'h0000;
      ctrl_r <= 8'h00;
      cnt_r <= 14'h0000;
      pwm_a_r <= 1'b0;
      pwm_b_r <= 1'b0;
    end else if (init) begin
      duty_a_r <= 16'h0000;
      duty_b_r <= 16'h0000;
      ctrl_r <= 8'h00;
      cnt_r <= 14'h0000;
      pwm_a_r <= 1'b0;
      pwm_b_r <= 1'b0;
    end else begin
      if (wr_ok && wr_sel == `PMS_SEL_DUTY_A)
        duty_a_r <= wdata;
      if (wr_ok && wr_sel == `PMS_SEL_DUTY_B)
        duty_b_r <= wdata;
      if (wr_ok && wr_sel == `PMS_SEL_CTRL)
        ctrl_r <= wdata[7:0];
      if (cnt_on) begin
        cnt_r <= (cnt_r == `PMS_CNT_MAX) ? 14'h0000 : cnt_r + 14'h0001;
        pwm_a_r <= (cnt_r < duty_a_r[13:0]);
        pwm_b_r <= (cnt_r < duty_b_r[13:0]);
      end
    end
  end
endmodule // pms_pwm_chan
`default_nettype wire

// [rtl/pms_adc_regs.v]
// converter register bank with its initialization conditions
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.vh"
module pms_adc_regs (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire init, // synchronous clear of all registers
  input wire wr_en, // register write strobe
  input wire [1:0] wr_sel, // register select
  input wire [7:0] wdata, // write data
  input wire [7:0] conv_data, // conversion result from converter
  input wire conv_valid, // conversion result strobe
  output reg [7:0] data_r, // result register
  output reg [7:0] csr_r, // control and status register
  output reg [7:0] cr_r // control register
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= 8'h00;
      csr_r <= 8'h00;
      cr_r <= 8'h00;
    end else if (init) begin
      data_r <= 8'h00;
      csr_r <= 8'h00;
      cr_r <= 8'h00;
    end else begin
      if (conv_valid)
        data_r <= conv_data;
      if (wr_en && wr_sel == `PMS_ADC_SEL_CSR)
        csr_r <= wdata;
      if (wr_en && wr_sel == `PMS_ADC_SEL_CR)
        cr_r <= wdata;
    end
  end
endmodule // pms_adc_regs
`default_nettype wire

// [rtl/pms_top.v]
// apb register slave, module-stop decode and register initialization control
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.vh"
module pms_top (
  input wire pclk, // system clock, 100 mhz
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction, high for write
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output reg pslverr, // apb error, unmapped address
  input wire wdt_reset, // watchdog reset pulse, same clock
  input wire sw_standby, // software standby state, same clock
  input wire hw_standby, // hardware standby state, same clock
  input wire adc_module_stop, // converter module stop, same clock
  input wire [7:0] adc_conv_data, // converter result
  input wire adc_conv_valid, // converter result strobe
  output wire pwm0_run, // channel 0 running
  output wire pwm1_run, // channel 1 running
  output wire pwm0_out_a, // channel 0 output a
  output wire pwm0_out_b, // channel 0 output b
  output wire pwm1_out_a, // channel 1 output a
  output wire pwm1_out_b // channel 1 output b
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode helpers

  function in_block;
    input [7:0] addr;
    input [7:0] base;
    begin
      in_block = (addr[7:4] == base[7:4]);
    end
  endfunction

  function [1:0] word_sel;
    input [7:0] addr;
    begin
      word_sel = addr[3:2];
    end
  endfunction

  // a channel runs only while the shared bit and its own bit are both clear
  function chan_run;
    input shared_stop;
    input own_stop;
    begin
      chan_run = ~shared_stop & ~own_stop;
    end
  endfunction

  // channel registers clear on watchdog, standby or while the channel is stopped
  function chan_init;
    input wdt;
    input stby;
    input run_i;
    begin
      chan_init = wdt | stby | ~run_i;
    end
  endfunction

  // read word of one channel's register bank
  function [31:0] chan_word;
    input [1:0] s;
    input [15:0] da;
    input [15:0] db;
    input [7:0] ctl;
    input [13:0] cnt;
    begin
      case (s)
        `PMS_SEL_DUTY_A: chan_word = {16'h0000, da};
        `PMS_SEL_DUTY_B: chan_word = {16'h0000, db};
        `PMS_SEL_CTRL: chan_word = {24'h00_0000, ctl};
        default: chan_word = {18'h0_0000, cnt};
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake

  wire setup_ph;
  wire access_ph;
  wire wr_access;
  wire [1:0] sel;
  wire hit_stop_a;
  wire hit_stop_h;
  wire hit_status;
  wire hit_ch0;
  wire hit_ch1;
  wire hit_adc;
  wire mapped;
  wire aligned;

  // zero wait: the read word is captured in the setup cycle
  assign pready = 1'b1;
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign sel = word_sel(paddr);
  assign aligned = (paddr[1:0] == 2'b00);
  assign hit_stop_a = aligned & (paddr == `PMS_OFS_STOP_A);
  assign hit_stop_h = aligned & (paddr == `PMS_OFS_STOP_H);
  assign hit_status = aligned & (paddr == `PMS_OFS_STATUS);
  assign hit_ch0 = aligned & in_block(paddr, `PMS_OFS_CH0);
  assign hit_ch1 = aligned & in_block(paddr, `PMS_OFS_CH1);
  assign hit_adc = aligned & in_block(paddr, `PMS_OFS_ADC) & (sel != 2'd3);
  assign mapped = hit_stop_a | hit_stop_h | hit_status | hit_ch0 | hit_ch1 | hit_adc;
  assign wr_access = access_ph & pwrite & mapped;

  ////////////////////////////////////////////////////////////////////////////
  // stop-control registers

  reg [7:0] peripheral_stop_control_a_r;
  reg shared_pwm_stop_bit_r;
  wire pwm_ch1_stop_bit;
  wire pwm_ch1_partner_ch0_stop_bit;

  assign pwm_ch1_stop_bit = peripheral_stop_control_a_r[`PMS_BIT_CH1_STOP];
  assign pwm_ch1_partner_ch0_stop_bit = peripheral_stop_control_a_r[`PMS_BIT_CH0_STOP];
  // reserved bits 7..3 and 0 are plain storage; software keeps them at zero

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_stop_control_a_r <= `PMS_STOP_A_RST;
      shared_pwm_stop_bit_r <= 1'b0;
    end else begin
      if (wr_access && hit_stop_a)
        peripheral_stop_control_a_r <= pwdata[7:0];
      if (wr_access && hit_stop_h)
        shared_pwm_stop_bit_r <= pwdata[`PMS_BIT_SHARED];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run decision per channel

  // the reserved shared=1 setting is treated as stopping both channels
  assign pwm1_run = chan_run(shared_pwm_stop_bit_r,
                             pwm_ch1_stop_bit);
  assign pwm0_run = chan_run(shared_pwm_stop_bit_r,
                             pwm_ch1_partner_ch0_stop_bit);

  ////////////////////////////////////////////////////////////////////////////
  // initialization conditions

  wire standby;
  wire pwm0_init;
  wire pwm1_init;
  wire adc_init;

  // sleep and speed changes are not listed, so registers are retained there
  assign standby = sw_standby | hw_standby;
  assign pwm1_init = chan_init(wdt_reset, standby, pwm1_run);
  assign pwm0_init = chan_init(wdt_reset, standby, pwm0_run);
  assign adc_init = wdt_reset | standby | adc_module_stop;

  ////////////////////////////////////////////////////////////////////////////
  // pwm channels and converter registers

  wire [15:0] ch0_duty_a;
  wire [15:0] ch0_duty_b;
  wire [7:0] ch0_ctrl;
  wire [13:0] ch0_cnt;
  wire [15:0] pwm_ch1_duty_a;
  wire [15:0] pwm_ch1_duty_b;
  wire [7:0] pwm_ch1_control;
  wire [13:0] pwm_ch1_counter;
  wire [7:0] adc_data;
  wire [7:0] adc_csr;
  wire [7:0] adc_cr;

  pms_pwm_chan u_pwm_channel_zero (
    .pclk(pclk),
    .presetn(presetn),
    .run(pwm0_run),
    .init(pwm0_init),
    .wr_en(wr_access & hit_ch0),
    .wr_sel(sel),
    .wdata(pwdata[15:0]),
    .duty_a_r(ch0_duty_a),
    .duty_b_r(ch0_duty_b),
    .ctrl_r(ch0_ctrl),
    .cnt_r(ch0_cnt),
    .pwm_a_r(pwm0_out_a),
    .pwm_b_r(pwm0_out_b)
  );

  pms_pwm_chan u_pwm_channel_one (
    .pclk(pclk),
    .presetn(presetn),
    .run(pwm1_run),
    .init(pwm1_init),
    .wr_en(wr_access & hit_ch1),
    .wr_sel(sel),
    .wdata(pwdata[15:0]),
    .duty_a_r(pwm_ch1_duty_a),
    .duty_b_r(pwm_ch1_duty_b),
    .ctrl_r(pwm_ch1_control),
    .cnt_r(pwm_ch1_counter),
    .pwm_a_r(pwm1_out_a),
    .pwm_b_r(pwm1_out_b)
  );

  pms_adc_regs u_adc_regs (
    .pclk(pclk),
    .presetn(presetn),
    .init(adc_init),
    .wr_en(wr_access & hit_adc),
    .wr_sel(sel),
    .wdata(pwdata[7:0]),
    .conv_data(adc_conv_data),
    .conv_valid(adc_conv_valid),
    .data_r(adc_data),
    .csr_r(adc_csr),
    .cr_r(adc_cr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h0000_0000;
    if (hit_stop_a)
      rd_nxt = {24'h00_0000, peripheral_stop_control_a_r};
    else if (hit_stop_h)
      rd_nxt = {28'h000_0000, shared_pwm_stop_bit_r, 3'b000};
    else if (hit_status)
      rd_nxt = {24'h00_0000, 3'b000, adc_module_stop, hw_standby, sw_standby,
                pwm1_run, pwm0_run};
    else if (hit_ch0)
      rd_nxt = chan_word(sel, ch0_duty_a, ch0_duty_b, ch0_ctrl, ch0_cnt);
    else if (hit_ch1)
      rd_nxt = chan_word(sel, pwm_ch1_duty_a, pwm_ch1_duty_b, pwm_ch1_control, pwm_ch1_counter);
    else if (hit_adc) begin
      case (sel)
        `PMS_ADC_SEL_DATA: rd_nxt = {24'h00_0000, adc_data};
        `PMS_ADC_SEL_CSR: rd_nxt = {24'h00_0000, adc_csr};
        default: rd_nxt = {24'h00_0000, adc_cr};
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      pslverr <= ~mapped;
    end
  end

endmodule // pms_top
`default_nettype wire

// [test/pms_top_asserts.sv]
// concurrent checks on the ports of the pwm module-stop block
`timescale 1ns/1ps
`default_nettype none
module pms_top_asserts (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic wdt_reset, // watchdog reset
  input wire logic sw_standby, // software standby
  input wire logic hw_standby, // hardware standby
  input wire logic pwm0_run, // channel 0 running
  input wire logic pwm1_run, // channel 1 running
  input wire logic pwm0_out_a, // channel 0 output a
  input wire logic pwm0_out_b, // channel 0 output b
  input wire logic pwm1_out_a, // channel 1 output a
  input wire logic pwm1_out_b // channel 1 output b
);
  logic c0_r;
  logic c1_r;
  logic sh_r;
  logic wr;
  logic init;
  assign wr = psel && penable && pwrite;
  assign init = wdt_reset || sw_standby || hw_standby;
  // shadow of the stop bits, taken from completed apb writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_r <= 1'b0;
      c1_r <= 1'b0;
      sh_r <= 1'b0;
    end else if (wr && paddr == 8'h00) begin
      c0_r <= pwdata[1];
      c1_r <= pwdata[2];
    end else if (wr && paddr == 8'h04) begin
      sh_r <= pwdata[3];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ch0_run_a: assert property (pwm0_run == !(sh_r || c0_r))
    else $error("channel 0 run state wrong");
  ch1_run_a: assert property (pwm1_run == !(sh_r || c1_r))
    else $error("channel 1 run state wrong");
  shared_stop_a: assert property (sh_r |-> !pwm0_run && !pwm1_run)
    else $error("shared stop left a channel running");
  status_read_a: assert property (psel && !penable && !pwrite && paddr == 8'h08
    |=> prdata[1:0] == {$past(pwm1_run), $past(pwm0_run)})
    else $error("status run bits wrong");
  ch0_quiet_a: assert property (!pwm0_run [*3] |-> !pwm0_out_a && !pwm0_out_b)
    else $error("stopped channel 0 drives output");
  ch1_quiet_a: assert property (!pwm1_run [*3] |-> !pwm1_out_a && !pwm1_out_b)
    else $error("stopped channel 1 drives output");
  init_quiet_a: assert property (init [*3] |-> !(pwm0_out_a || pwm1_out_a))
    else $error("output active during init");
  ch1_held_a: assert property (psel && !penable && paddr == 8'h20 && !pwm1_run
    |=> prdata == 32'h0)
    else $error("stopped channel 1 register not clear");
endmodule // pms_top_asserts
bind pms_top pms_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .wdt_reset(wdt_reset), .sw_standby(sw_standby), .hw_standby(hw_standby),
  .pwm0_run(pwm0_run), .pwm1_run(pwm1_run), .pwm0_out_a(pwm0_out_a),
  .pwm0_out_b(pwm0_out_b), .pwm1_out_a(pwm1_out_a), .pwm1_out_b(pwm1_out_b));
`default_nettype wire

// [test/tb_top.sv]
// self-checking testbench for the pwm module-stop block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic wdt_reset, sw_standby, hw_standby, adc_module_stop, adc_conv_valid;
  logic [7:0] adc_conv_data;
  logic pwm0_run, pwm1_run, pwm0_out_a, pwm0_out_b, pwm1_out_a, pwm1_out_b;
  int mismatches, checks_done;
  pms_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdt_reset(wdt_reset), .sw_standby(sw_standby),
    .hw_standby(hw_standby), .adc_module_stop(adc_module_stop),
    .adc_conv_data(adc_conv_data), .adc_conv_valid(adc_conv_valid),
    .pwm0_run(pwm0_run), .pwm1_run(pwm1_run), .pwm0_out_a(pwm0_out_a),
    .pwm0_out_b(pwm0_out_b), .pwm1_out_a(pwm1_out_a), .pwm1_out_b(pwm1_out_b));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one apb transfer; holds the request until pready is seen high or 50 access cycles pass
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) mismatches++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    xfer(8'h00, 1'b0, 32'h0);
    chk("stop_a reset", rd, 32'h0);
    xfer(8'h04, 1'b0, 32'h0);
    chk("stop_h reset", rd, 32'h0);
    xfer(8'h08, 1'b0, 32'h0);
    chk("status reset", rd[1:0], 32'h3);
    chk("mapped err", pslverr, 32'h0);
    xfer(8'h3c, 1'b0, 32'h0);
    chk("unmapped err", pslverr, 32'h1);
    $display("test reset done");
  endtask
  task t_stop;
    for (int i = 0; i < 4; i++) begin
      xfer(8'h00, 1'b1, 32'(i << 1));
      chk("ch0 run", pwm0_run, 32'(!i[0]));
      chk("ch1 run", pwm1_run, 32'(!i[1]));
      xfer(8'h00, 1'b0, 32'h0);
      chk("stop_a read", rd, 32'(i << 1));
      xfer(8'h20, 1'b1, 32'h55);
      xfer(8'h20, 1'b0, 32'h0);
      chk("ch1 duty gated", rd, i[1] ? 32'h0 : 32'h55);
    end
    xfer(8'h00, 1'b1, 32'h0);
    xfer(8'h04, 1'b1, 32'h8);
    chk("shared ch0", pwm0_run, 32'h0);
    chk("shared ch1", pwm1_run, 32'h0);
    xfer(8'h04, 1'b1, 32'h0);
    chk("shared off", {pwm1_run, pwm0_run}, 32'h3);
    $display("test stop done");
  endtask
  task t_pwm;
    xfer(8'h10, 1'b1, 32'h10);
    xfer(8'h18, 1'b1, 32'h1);
    @(posedge pclk);
    #1;
    chk("ch0 out a", pwm0_out_a, 32'h1);
    chk("ch0 out b", pwm0_out_b, 32'h0);
    xfer(8'h24, 1'b1, 32'h10);
    xfer(8'h28, 1'b1, 32'h1);
    @(posedge pclk);
    #1;
    chk("ch1 out a", pwm1_out_a, 32'h0);
    chk("ch1 out b", pwm1_out_b, 32'h1);
    xfer(8'h00, 1'b1, 32'h2);
    xfer(8'h10, 1'b1, 32'h33);
    xfer(8'h10, 1'b0, 32'h0);
    chk("stopped duty", rd, 32'h0);
    xfer(8'h00, 1'b1, 32'h0);
    xfer(8'h18, 1'b0, 32'h0);
    chk("resumed ctrl", rd, 32'h0);
    chk("resumed out", pwm0_out_a, 32'h0);
    $display("test pwm done");
  endtask
  task t_init;
    for (int i = 0; i < 4; i++) begin
      xfer(8'h20, 1'b1, 32'h1234);
      xfer(8'h34, 1'b1, 32'h5a);
      @(posedge pclk);
      adc_conv_data <= 8'ha5;
      adc_conv_valid <= 1'b1;
      @(posedge pclk);
      adc_conv_valid <= 1'b0;
      xfer(8'h30, 1'b0, 32'h0);
      chk("adc result", rd, 32'ha5);
      @(posedge pclk);
      {adc_module_stop, hw_standby, sw_standby, wdt_reset} <= 4'(1 << i);
      repeat (4) @(posedge pclk);
      {adc_module_stop, hw_standby, sw_standby, wdt_reset} <= 4'h0;
      xfer(8'h20, 1'b0, 32'h0);
      chk("ch1 duty", rd, (i == 3) ? 32'h1234 : 32'h0);
      xfer(8'h34, 1'b0, 32'h0);
      chk("adc csr", rd, 32'h0);
      xfer(8'h30, 1'b0, 32'h0);
      chk("adc cleared", rd, 32'h0);
    end
    $display("test init done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  initial begin
    {presetn, psel, penable, pwrite, wdt_reset, sw_standby} = 6'h0;
    {hw_standby, adc_module_stop, adc_conv_valid} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    adc_conv_data = 8'h00;
    mismatches = 0;
    checks_done = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_stop();
    t_pwm();
    t_init();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
